// File: verif/adcseq_props.sv
// port assertions for the converter sequencer
`timescale 1ns/10ps
module adcseq_props
  import adcseq_pkg::*;
(
  // clock, reset, bus and sleep
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_SLEEP,
  // outputs watched
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_CONV_POWER,
  input wire logic O_CONV_SAMPLE,
  input wire logic O_WAKE_REQ,
  input wire logic O_DONE_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  logic [4:0] len_q;
  logic [4:0] len_d;
  // a counter, since a repetition of twelve is too long to unroll
  assign len_d = O_CONV_SAMPLE ? len_q + 5'h01 : 5'h00;
  always_ff @(posedge I_CLK) len_q <= I_RESETN ? len_d : 5'h00;
  a_conv_len: assert property (
    $fell(O_CONV_SAMPLE) |-> len_q == CONV_CYC) else $error("bad length");
  a_done_set: assert property (
    $fell(O_CONV_SAMPLE) |-> ##[0:1] O_DONE_IRQ) else $error("no done");
  a_sample_pwr: assert property (
    O_CONV_SAMPLE |-> O_CONV_POWER) else $error("sample unpowered");
  a_wake_pulse: assert property (
    O_WAKE_REQ |=> !O_WAKE_REQ) else $error("wake too long");
  a_wake_done: assert property (
    O_WAKE_REQ |-> ##[0:1] O_DONE_IRQ) else $error("wake without done");
  a_wake_sleep: assert property (
    O_WAKE_REQ |-> $past(I_SLEEP, 3)) else $error("wake while awake");
  a_ready_once: assert property (
    O_PREADY |=> !O_PREADY) else $error("ready too long");
  a_ready_due: assert property (
    I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY) else $error("no ready");
  a_err_ready: assert property (
    O_PSLVERR |-> O_PREADY) else $error("slverr alone");
endmodule : adcseq_props

// File: verif/tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb_top;
  import adcseq_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, slp = 1'b0, e, power, sample, wake, irq;
  logic        pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic [31:0] lf = 32'h00013FC3;
  logic [12:0] trig = 13'h0000;
  logic [9:0]  cdata = 10'h000, d1, d2;
  logic [5:0]  chan;
  logic [15:0] e0, ea;
  logic [5:0]  codes [6] = '{6'h3F, 6'h3E, 6'h3D, 6'h3C, 6'h3B, 6'h22};
  int          n_errors = 0, compares = 0, wakes = 0, n0, n1;
  always #4 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes++;
  adcseq_top u_dut (
    .I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TRIG_SRC(trig), .I_SLEEP(slp), .I_CONV_DATA(cdata),
    .O_CONV_POWER(power), .O_CONV_SAMPLE(sample), .O_CHAN_SEL(chan),
    .O_WAKE_REQ(wake), .O_DONE_IRQ(irq));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] ex, sn);
    compares++;
    if (sn !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // waits for the done flag, then clears it
  task automatic idle;
    while (irq !== 1'b1) @(posedge clk);
    apb(1'b1, ADR_STAT, 32'h00000001);
  endtask : idle
  task automatic conv(input logic [6:0] c, input logic [9:0] d, output int n);
    cdata <= d;
    apb(1'b1, ADR_CTRL, {25'h0, c});
    apb(1'b1, ADR_CTRL, {25'h0, c | 7'h02});
    n = 0;
    while (sample !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    idle;
  endtask : conv
  task automatic nap(input logic [6:0] c);
    apb(1'b1, ADR_CTRL, {25'h0, c});
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    trig[0] <= 1'b1;
    repeat (40) @(posedge clk);
  endtask : nap
  task automatic wake_up;
    slp <= 1'b0;
    trig <= 13'h0000;
    idle;
  endtask : wake_up
  task automatic wrap_up;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADR_CHAN, 32'h0);
    chk("chan reset", {26'h0, CHAN_RST}, r);
    for (int i = 0; i < 6; i++) begin
      lf = nxt(lf);
      apb(1'b1, ADR_CHAN, {lf[31:6], codes[i]});
      apb(1'b0, ADR_CHAN, 32'h0);
      chk("chan", {26'h0, codes[i]}, r);
      chk("chan out", {26'h0, codes[i]}, {26'h0, chan});
    end
    apb(1'b1, 8'h28, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, ADR_CTRL, 32'h2);
    repeat (20) @(posedge clk);
    chk("off idle", 32'h0, {31'h0, sample | irq});
    $display("register test done");
    lf = nxt(lf);
    d1 = lf[9:0];
    d2 = lf[19:10] | 10'h200;
    apb(1'b1, ADR_STAT, 32'h100);
    apb(1'b1, ADR_SETPT, {23'h0, lf[28:20]});
    apb(1'b1, ADR_THRESH, 32'h0);
    conv(7'h09, d1, n0);
    conv(7'h09, d2, n0);
    apb(1'b0, ADR_RES, 32'h0);
    chk("result", {22'h0, d2}, r);
    apb(1'b0, ADR_PREV, 32'h0);
    chk("previous", {22'h0, d1}, r);
    apb(1'b0, ADR_ACC, 32'h0);
    chk("accum", 32'(d1) + 32'(d2), r);
    apb(1'b0, ADR_ERR, 32'h0);
    chk("error", 32'(16'(d2) - 16'(lf[28:20])), {16'h0, r[15:0]});
    apb(1'b0, ADR_STAT, 32'h0);
    chk("math thr", 32'h6, {29'h0, r[2:0]});
    apb(1'b0, ADR_CTRL, 32'h0);
    chk("go clear", 32'h0, {31'h0, r[CTL_GO]});
    conv(7'h21, d1, n1);
    chk("rc delay", 32'(INSTR_CYC), 32'(n1 - n0));
    // double sampling: error updates after exactly one of two conversions
    apb(1'b1, ADR_SETPT, 32'h0);
    apb(1'b0, ADR_ERR, 32'h0);
    e0 = r[15:0];
    conv(7'h11, ~e0[9:0], n1);
    apb(1'b0, ADR_ERR, 32'h0);
    ea = r[15:0];
    conv(7'h11, ~e0[9:0] ^ 10'h001, n1);
    apb(1'b0, ADR_ERR, 32'h0);
    chk("dsen", 32'h1, {31'h0, (ea != e0) ^ (r[15:0] != ea)});
    conv(7'h05, d2, n1);
    apb(1'b0, ADR_CTRL, 32'h0);
    chk("go kept", 32'h1, {31'h0, r[CTL_GO]});
    apb(1'b1, ADR_CTRL, 32'h3);
    idle;
    $display("conversion test done");
    apb(1'b1, ADR_CTRL, 32'h1);
    for (int k = 1; k <= 16; k++) begin
      lf = nxt(lf);
      cdata <= lf[9:0];
      apb(1'b1, ADR_TRIG, 32'(k));
      if (k <= NUM_HWTRG) trig[k - 1] <= 1'b1;
      else if (k == 16) apb(1'b1, ADR_CHAN, 32'h5);
      else apb(1'b0, k == 14 ? ADR_ERR : ADR_RES, 32'h0);
      idle;
      trig <= 13'h0000;
      apb(1'b1, ADR_TRIG, 32'h0);
      apb(1'b0, ADR_RES, 32'h0);
      chk("trig result", {22'h0, lf[9:0]}, r);
    end
    $display("trigger test done");
    apb(1'b1, ADR_TRIG, 32'h1);
    nap(7'h61);
    chk("wake", 32'h1, 32'(wakes));
    wake_up;
    nap(7'h21);
    chk("sleep done", 32'h1, {31'h0, irq});
    chk("power off", 32'h0, {31'h0, power});
    apb(1'b0, ADR_STAT, 32'h0);
    chk("pwrdn", 32'h1, {31'h0, r[ST_PWRDN]});
    apb(1'b0, ADR_CTRL, 32'h0);
    chk("on kept", 32'h1, {31'h0, r[CTL_ON]});
    chk("no wake", 32'h1, 32'(wakes));
    wake_up;
    apb(1'b1, ADR_CTRL, 32'h0);
    nap(7'h01);
    chk("held", 32'h0, {31'h0, irq | sample});
    apb(1'b0, ADR_STAT, 32'h0);
    chk("pending", 32'h1, {31'h0, r[ST_PEND]});
    wake_up;
    $display("sleep test done");
    wrap_up();
  end
endmodule : tb_top
bind adcseq_top adcseq_props u_props (
  .I_CLK, .I_RESETN, .I_PSEL, .I_PENABLE, .I_SLEEP, .O_PREADY, .O_PSLVERR,
  .O_CONV_POWER, .O_CONV_SAMPLE, .O_WAKE_REQ, .O_DONE_IRQ);

// File: verilog/adcseq_edge.sv
// synchroniser and rising-edge detector for one trigger source
`timescale 1ns/10ps
module adcseq_edge (
  // clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RESETN,
  // asynchronous level in, one-cycle pulse out
  input  wire logic i_level,
  output logic      o_rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // s1 feeds s2 only; the edge is taken between s2 and s3
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_level;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign o_rise = s2_q & ~s3_q;
endmodule : adcseq_edge

// File: verilog/adcseq_pkg.sv
// package for the converter sequencer: offsets, fields, reset values
package adcseq_pkg;
  // register byte offsets (apb, one word each)
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_TRIG   = 8'h04;
  localparam logic [7:0] ADR_CHAN   = 8'h08;
  localparam logic [7:0] ADR_STAT   = 8'h0C;
  localparam logic [7:0] ADR_RES    = 8'h10;
  localparam logic [7:0] ADR_PREV   = 8'h14;
  localparam logic [7:0] ADR_ACC    = 8'h18;
  localparam logic [7:0] ADR_ERR    = 8'h1C;
  localparam logic [7:0] ADR_SETPT  = 8'h20;
  localparam logic [7:0] ADR_THRESH = 8'h24;
  // control register bit positions
  localparam int CTL_ON    = 0;
  localparam int CTL_GO    = 1;
  localparam int CTL_CONT  = 2;
  localparam int CTL_PSIS  = 3;
  localparam int CTL_DSEN  = 4;
  localparam int CTL_RC    = 5;
  localparam int CTL_IE    = 6;
  // status register bit positions
  localparam int ST_DONE   = 0;
  localparam int ST_MATH   = 1;
  localparam int ST_THR    = 2;
  localparam int ST_PEND   = 3;
  localparam int ST_BUSY   = 4;
  localparam int ST_PWRDN  = 5;
  // reset values
  localparam logic [6:0]  CTRL_RST = 7'h00;
  localparam logic [4:0]  TRIG_RST = 5'h00;
  localparam logic [5:0]  CHAN_RST = 6'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // trigger source codes (auto_trigger_select field)
  localparam logic [4:0] TRG_NONE  = 5'h00;
  localparam int         NUM_HWTRG = 13;
  localparam logic [4:0] TRG_ERRRD = 5'h0E;
  localparam logic [4:0] TRG_RESRD = 5'h0F;
  localparam logic [4:0] TRG_CHWR  = 5'h10;
  // channel codes
  localparam logic [5:0] CH_FIXREF = 6'h3F;
  localparam logic [5:0] CH_DAC    = 6'h3E;
  localparam logic [5:0] CH_TEMP   = 6'h3D;
  localparam logic [5:0] CH_AGND   = 6'h3C;
  localparam logic [5:0] CH_RSVD   = 6'h3B;
  localparam logic [5:0] CH_PINMAX = 6'h22;
  // timing: conversion length in clocks, extra instruction cycle for rc
  localparam logic [4:0] CONV_CYC  = 5'd12;
  localparam logic [4:0] INSTR_CYC = 5'd4;
endpackage : adcseq_pkg

// File: verilog/adcseq_top.sv
// converter sequencer: apb registers, start logic, completion, sleep
//
// Behaviour
// - no conversion activity unless converter_on is set.
// - start on software go, selected trigger, or continuous retrigger.
// - with previous_source_select set, old result moves to previous_value.
// - completion clears conversion_go unless continuous_mode is set.
// - completion sets done flag, computation_complete, updates accumulator.
// - error each conversion, or every second with double sampling.
// - threshold computation runs after completion, one cycle later.
// - conversions proceed in sleep only on the dedicated rc clock.
// - with rc clock, start waits one extra instruction cycle.
// - completion in sleep with interrupt enabled requests wake-up.
// - completion in sleep with interrupt disabled powers converter down.
// - trigger in sleep on rc clock runs a full conversion.
// - trigger in sleep on other clocks stays pending until wake.
// - rising edge of selected source sets conversion_go by hardware.
// - trigger source chosen by five-bit auto_trigger_select field.
// - sources: pin, timers, capture-compare, pwm, comparators, pin change.
// - sources also: error-high read, result-high read, channel write.
`timescale 1ns/10ps
module adcseq_top
  import adcseq_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // hardware trigger sources, asynchronous levels, index = code - 1
  input  wire logic [12:0] I_TRIG_SRC,
  // device sleep state
  input  wire logic        I_SLEEP,
  // analog converter core
  input  wire logic [9:0]  I_CONV_DATA,
  output logic             O_CONV_POWER,
  output logic             O_CONV_SAMPLE,
  output logic [5:0]       O_CHAN_SEL,
  // system
  output logic             O_WAKE_REQ,
  output logic             O_DONE_IRQ
);

  typedef enum logic [1:0] {S_IDLE, S_DELAY, S_CONV} adcseq_state_t;

  adcseq_state_t state_q, state_d;
  logic [6:0]  ctrl_q;
  logic [4:0]  trig_q;
  logic [5:0]  chan_q;
  logic [15:0] res_q, prev_q, acc_q, err_q, setpt_q, thresh_q;
  logic        done_q, math_q, thr_q, pend_q, pwrdn_q, half_q;
  logic        calc_q;
  logic [4:0]  cnt_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        wake_q;
  logic [12:0] trig_rise;

  // zero extend helper for result and accumulator
  function automatic logic [15:0] ext10(input logic [9:0] v);
    ext10 = {6'h00, v};
  endfunction : ext10

  // synchronise each hardware trigger and find its rising edge
  genvar g;
  generate
    for (g = 0; g < NUM_HWTRG; g++) begin : g_trg
      adcseq_edge u_edge (
        .I_CLK    (I_CLK),
        .I_RESETN (I_RESETN),
        .i_level  (I_TRIG_SRC[g]),
        .o_rise   (trig_rise[g])
      );
    end
  endgenerate

  logic sleep_s1_q, sleep_q;
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      sleep_s1_q <= 1'b0;
      sleep_q    <= 1'b0;
    end else begin
      sleep_s1_q <= I_SLEEP;
      sleep_q    <= sleep_s1_q;
    end
  end

  // apb decode; access completes in its second access cycle (one wait state)
  wire acc_en   = I_PSEL & I_PENABLE & ~pready_q;
  wire wr_en    = acc_en & I_PWRITE;
  wire rd_en    = acc_en & ~I_PWRITE;
  wire wr_ctrl  = wr_en & (I_PADDR == ADR_CTRL);
  wire wr_trig  = wr_en & (I_PADDR == ADR_TRIG);
  wire wr_chan  = wr_en & (I_PADDR == ADR_CHAN);
  wire wr_stat  = wr_en & (I_PADDR == ADR_STAT);
  wire wr_setpt = wr_en & (I_PADDR == ADR_SETPT);
  wire wr_thr   = wr_en & (I_PADDR == ADR_THRESH);
  wire rd_err   = rd_en & (I_PADDR == ADR_ERR);
  wire rd_res   = rd_en & (I_PADDR == ADR_RES);
  wire addr_ok  = (I_PADDR[1:0] == 2'b00) && (I_PADDR <= ADR_THRESH);

  // selected source: hardware edge or register access event
  wire hw_sel   = (trig_q != TRG_NONE) && (trig_q <= 5'(NUM_HWTRG));
  // padded to sixteen so every four-bit index stays in range
  wire [15:0] rise_all = {3'b000, trig_rise};
  wire hw_hit   = hw_sel && rise_all[4'(trig_q - 5'd1)];
  wire reg_hit  = (trig_q == TRG_ERRRD && rd_err)
               || (trig_q == TRG_RESRD && rd_res)
               || (trig_q == TRG_CHWR  && wr_chan);
  wire trig_ev  = hw_hit | reg_hit;

  wire on       = ctrl_q[CTL_ON];
  wire rc_clk   = ctrl_q[CTL_RC];
  // sleep on a non-rc clock halts the converter
  wire halted   = sleep_q & ~rc_clk;
  wire go_now   = ctrl_q[CTL_GO] | pend_q;
  wire finish   = (state_q == S_CONV) && (cnt_q == 5'd1);
  wire may_run  = on & ~halted & ~pwrdn_q;
  wire do_err   = ~ctrl_q[CTL_DSEN] | half_q;

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (may_run && go_now) begin
          state_d = rc_clk ? S_DELAY : S_CONV;
        end
      end
      S_DELAY: begin
        if (!on) begin
          state_d = S_IDLE;
        end else if (cnt_q == 5'd1) begin
          state_d = S_CONV;
        end
      end
      S_CONV: begin
        if (!on || halted) begin
          state_d = S_IDLE;
        end else if (finish) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_q <= S_IDLE;
      cnt_q   <= 5'd0;
    end else begin
      state_q <= state_d;
      if (state_q != S_DELAY && state_d == S_DELAY) begin
        cnt_q <= INSTR_CYC;
      end else if (state_q != S_CONV && state_d == S_CONV) begin
        cnt_q <= CONV_CYC;
      end else if (cnt_q != 5'd0) begin
        cnt_q <= cnt_q - 5'd1;
      end
    end
  end

  // control, trigger and channel registers
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      ctrl_q <= CTRL_RST;
      trig_q <= TRIG_RST;
      chan_q <= CHAN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= I_PWDATA[6:0];
      end
      // hardware set of go wins over any clear in the same cycle
      if (on && trig_ev) begin
        ctrl_q[CTL_GO] <= 1'b1;
      end else if (finish && !ctrl_q[CTL_CONT]) begin
        ctrl_q[CTL_GO] <= 1'b0;
      end
      if (wr_trig) begin
        trig_q <= I_PWDATA[4:0];
      end
      if (wr_chan) begin
        chan_q <= I_PWDATA[5:0];
      end
    end
  end

  // trigger in sleep without rc clock: remember it until wake
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      pend_q <= 1'b0;
    end else if (on && trig_ev && halted) begin
      pend_q <= 1'b1;
    end else if (state_q == S_CONV) begin
      pend_q <= 1'b0;
    end
  end

  // completion: result, previous value, accumulator, flags
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      res_q  <= WORD_RST;
      prev_q <= WORD_RST;
      acc_q  <= WORD_RST;
      done_q <= 1'b0;
      math_q <= 1'b0;
      half_q <= 1'b0;
      calc_q <= 1'b0;
    end else begin
      calc_q <= 1'b0;
      if (finish) begin
        if (ctrl_q[CTL_PSIS]) begin
          prev_q <= res_q;
        end
        res_q  <= ext10(I_CONV_DATA);
        acc_q  <= acc_q + ext10(I_CONV_DATA);
        half_q <= ~half_q;
        calc_q <= do_err;
      end
      // set wins over a software clear in the same cycle
      if (finish) begin
        done_q <= 1'b1;
        math_q <= 1'b1;
      end else if (wr_stat) begin
        done_q <= done_q & ~I_PWDATA[ST_DONE];
        math_q <= math_q & ~I_PWDATA[ST_MATH];
      end
      if (wr_stat && I_PWDATA[8]) begin
        acc_q <= WORD_RST;
      end
    end
  end

  // error and threshold one cycle after the result lands
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      err_q    <= WORD_RST;
      thr_q    <= 1'b0;
      setpt_q  <= WORD_RST;
      thresh_q <= WORD_RST;
    end else begin
      if (wr_setpt) begin
        setpt_q <= I_PWDATA[15:0];
      end
      if (wr_thr) begin
        thresh_q <= I_PWDATA[15:0];
      end
      if (calc_q) begin
        err_q <= res_q - setpt_q;
      end
      if (calc_q && ($signed(res_q - setpt_q) > $signed(thresh_q))) begin
        thr_q <= 1'b1;
      end else if (wr_stat) begin
        thr_q <= thr_q & ~I_PWDATA[ST_THR];
      end
    end
  end

  // sleep completion: wake when enabled, else power down (on stays set)
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      pwrdn_q <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      wake_q <= finish & sleep_q & ctrl_q[CTL_IE];
      if (finish && sleep_q && !ctrl_q[CTL_IE]) begin
        pwrdn_q <= 1'b1;
      end else if (!sleep_q || (wr_ctrl && !I_PWDATA[CTL_ON])) begin
        pwrdn_q <= 1'b0;
      end
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (I_PADDR)
      ADR_CTRL:   rd_mux = {25'h0, ctrl_q};
      ADR_TRIG:   rd_mux = {27'h0, trig_q};
      ADR_CHAN:   rd_mux = {26'h0, chan_q};
      ADR_STAT:   rd_mux = {26'h0, pwrdn_q, (state_q != S_IDLE), pend_q,
                            thr_q, math_q, done_q};
      ADR_RES:    rd_mux = {16'h0, res_q};
      ADR_PREV:   rd_mux = {16'h0, prev_q};
      ADR_ACC:    rd_mux = {16'h0, acc_q};
      ADR_ERR:    rd_mux = {16'h0, err_q};
      ADR_SETPT:  rd_mux = {16'h0, setpt_q};
      ADR_THRESH: rd_mux = {16'h0, thresh_q};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc_en;
      pslverr_q <= acc_en & ~addr_ok;
      if (rd_en) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // outputs, each from a flip-flop
  logic       pwr_q, smp_q;
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      pwr_q <= 1'b0;
      smp_q <= 1'b0;
    end else begin
      pwr_q <= may_run;
      smp_q <= (state_d == S_CONV);
    end
  end

  // channel code decoded by the analog mux; reserved code connects nothing
  assign O_CHAN_SEL    = chan_q;
  assign O_PRDATA      = prdata_q;
  assign O_PREADY      = pready_q;
  assign O_PSLVERR     = pslverr_q;
  assign O_CONV_POWER  = pwr_q;
  assign O_CONV_SAMPLE = smp_q;
  assign O_WAKE_REQ    = wake_q;
  assign O_DONE_IRQ    = done_q;
endmodule : adcseq_top
